// >>> include/core_ops_cfg.svh
// Opcode patterns, register offsets, field positions and reset values of the execution core
`ifndef CORE_OPS_CFG_SVH
`define CORE_OPS_CFG_SVH

// ==================================================
// Instruction encodings
`define OP_CALL_MASK 14'h3800
`define OP_CALL_VAL 14'h2000
`define OP_WDCLR_VAL 14'h0064
`define OP_CLR_MASK 14'h3F80
`define OP_REGCLR_VAL 14'h0180
`define OP_ACCCLR_VAL 14'h0100
`define OP_ALU_MASK 14'h3F00
`define OP_INV_VAL 14'h0900
`define OP_DEC_VAL 14'h0300
`define OP_DECSKIP_VAL 14'h0B00

// ==================================================
// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_PCLH 8'h04
`define OFS_STATUS 8'h08
`define OFS_ACC 8'h0C
`define OFS_PC 8'h10

// ==================================================
// Field positions
`define CTRL_RUN_BIT 0
`define CTRL_PSA_BIT 1
`define ST_Z_BIT 0
`define ST_PD_BIT 3
`define ST_TO_BIT 4

// ==================================================
// Values and steps
`define RST_PCLH 8'h00
`define CLEAR_BYTE 8'h00
`define PC_STEP 13'h0001
`define DEC_STEP 8'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STACK_DEPTH 8

`endif

// >>> include/core_ops_pkg.sv
// Types shared by the execution core and its return stack
package core_ops_pkg;

  // ==================================================
  // AXI4-Lite request and response bundles
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // ==================================================
  // Decoded instruction class, one-hot
  typedef enum logic [7:0] {
    KIND_NONE = 8'h01,
    KIND_CALL = 8'h02,
    KIND_WDCLR = 8'h04,
    KIND_REGCLR = 8'h08,
    KIND_ACCCLR = 8'h10,
    KIND_INV = 8'h20,
    KIND_DEC = 8'h40,
    KIND_DECSKIP = 8'h80
  } op_kind_t;

  // ==================================================
  // Core state
  typedef struct packed {
    logic [12:0] pc;
    logic [12:0] exec_pc;
    logic [7:0] acc;
    logic z;
    logic to_n;
    logic pd_n;
    logic flush;
    logic run;
    logic psa;
    logic [7:0] pc_high_latch;
    logic wdt_clear;
    logic prescaler_clear;
    axil_rsp_t rsp;
  } core_state_t;

  typedef struct packed {
    logic [2:0] ptr;
    logic [12:0] top;
  } stack_state_t;

endpackage

// >>> logic/return_stack.sv
// Circular eight-level return address stack, push side only
`timescale 1ns/1ps
`include "core_ops_cfg.svh"

module return_stack
  import core_ops_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Push port
  input wire logic push,
  input wire logic [12:0] push_data,
  // Current top entry
  output logic [12:0] top
);

  logic [12:0] slots [0:`STACK_DEPTH-1];
  stack_state_t cur;
  stack_state_t nxt;

  // A ninth push wraps and overwrites the oldest entry, no overflow flag
  always_comb
  begin
    nxt = cur;
    if (push)
    begin
      nxt.ptr = cur.ptr + 3'h1;
      nxt.top = push_data;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= nxt;
  end

  // Slot storage needs no reset
  always_ff @(posedge sys_clk)
  begin
    if (push)
      slots[nxt.ptr] <= push_data;
  end

  assign top = cur.top;

endmodule

// >>> logic/core_exec_ops.sv
// Execution core for call, watchdog clear, clear, complement and decrement instructions
`timescale 1ns/1ps
`include "core_ops_cfg.svh"

module core_exec_ops
  import core_ops_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Program memory, one cycle read latency
  output logic [12:0] prog_addr,
  input wire logic [13:0] instr_word,
  // Watchdog clear interface
  input wire logic watchdog_timeout,
  output logic wdt_clear,
  output logic prescaler_clear,
  // Return stack observation
  output logic [12:0] stack_top_entry,
  // Register bus
  input wire axil_req_t axil_req,
  output axil_rsp_t axil_rsp
);

  // ==================================================
  // Decode
  function automatic op_kind_t decode_op(input logic [13:0] w);
    op_kind_t k;
    k = KIND_NONE;
    if ((w & `OP_CALL_MASK) == `OP_CALL_VAL)
      k = KIND_CALL;
    else if (w == `OP_WDCLR_VAL)
      k = KIND_WDCLR;
    else if ((w & `OP_CLR_MASK) == `OP_REGCLR_VAL)
      k = KIND_REGCLR;
    else if ((w & `OP_CLR_MASK) == `OP_ACCCLR_VAL)
      k = KIND_ACCCLR;
    else if ((w & `OP_ALU_MASK) == `OP_INV_VAL)
      k = KIND_INV;
    else if ((w & `OP_ALU_MASK) == `OP_DEC_VAL)
      k = KIND_DEC;
    else if ((w & `OP_ALU_MASK) == `OP_DECSKIP_VAL)
      k = KIND_DECSKIP;
    return k;
  endfunction

  localparam core_state_t RESET_STATE = '{
    pc: '0, exec_pc: '0, acc: `CLEAR_BYTE, z: 1'b0, to_n: 1'b1, pd_n: 1'b1,
    flush: 1'b1, run: 1'b0, psa: 1'b0, pc_high_latch: `RST_PCLH,
    wdt_clear: 1'b0, prescaler_clear: 1'b0, rsp: '0};

  core_state_t cur;
  core_state_t nxt;
  logic [7:0] file_mem [0:127];
  op_kind_t kind;
  logic exec_ok;
  logic [6:0] f_addr;
  logic dest;
  logic [7:0] operand;
  logic [7:0] inv_res;
  logic [7:0] dec_res;
  logic [7:0] alu_res;
  logic file_wr;
  logic [7:0] file_wdata;
  logic push_call;
  logic [12:0] call_target;
  logic wr_fire;
  logic rd_fire;

  // Flushed slots and a stopped core execute nothing
  assign exec_ok = cur.run && !cur.flush;
  assign kind = exec_ok ? decode_op(instr_word) : KIND_NONE;
  assign f_addr = instr_word[6:0];
  assign dest = instr_word[7];
  assign operand = file_mem[f_addr];
  assign inv_res = ~operand;
  assign dec_res = operand - `DEC_STEP;
  assign alu_res = (kind == KIND_INV) ? inv_res : dec_res;
  assign call_target = {cur.pc_high_latch[4:3], instr_word[10:0]};
  assign push_call = (kind == KIND_CALL);

  // Register file write: register clear always, ALU ops only with destination set
  // clear writes zero
  assign file_wr = (kind == KIND_REGCLR)
    || (((kind == KIND_INV) || (kind == KIND_DEC) || (kind == KIND_DECSKIP)) && dest);
  assign file_wdata = (kind == KIND_REGCLR) ? `CLEAR_BYTE : alu_res;

  // Bus handshakes complete while ready is high
  assign wr_fire = cur.rsp.awready && axil_req.awvalid && axil_req.wvalid;
  assign rd_fire = cur.rsp.arready && axil_req.arvalid;

  // ==================================================
  // Next state
  always_comb
  begin
    logic [31:0] rd_word;
    rd_word = '0;
    nxt = cur;
    nxt.wdt_clear = 1'b0;
    nxt.prescaler_clear = 1'b0;
    nxt.flush = 1'b0;
    if (!cur.run)
    begin
      // Rewind so the unexecuted word is fetched again on resume
      nxt.pc = cur.flush ? cur.pc : cur.exec_pc;
      nxt.flush = 1'b1;
    end
    else
    begin
      nxt.exec_pc = cur.pc;
      nxt.pc = cur.pc + `PC_STEP;
    end
    case (kind)
      KIND_CALL:
      begin
        nxt.pc = call_target;
        nxt.flush = 1'b1;
      end
      KIND_WDCLR:
      begin
        nxt.wdt_clear = 1'b1;
        nxt.prescaler_clear = cur.psa;
        nxt.to_n = 1'b1;
        nxt.pd_n = 1'b1;
      end
      KIND_REGCLR:
        nxt.z = 1'b1;
      KIND_ACCCLR:
      begin
        nxt.acc = `CLEAR_BYTE;
        nxt.z = 1'b1;
      end
      KIND_INV, KIND_DEC:
      begin
        if (!dest)
          nxt.acc = alu_res;
        nxt.z = (alu_res == `CLEAR_BYTE);
      end
      KIND_DECSKIP:
      begin
        if (!dest)
          nxt.acc = dec_res;
        if (dec_res == `CLEAR_BYTE)
          nxt.flush = 1'b1;
      end
      default:
      begin
      end
    endcase
    // A timeout in the same cycle as a clear still lands
    if (watchdog_timeout)
      nxt.to_n = 1'b0;

    // Bus write channel: take address and data together
    nxt.rsp.awready = axil_req.awvalid && axil_req.wvalid && !cur.rsp.awready
      && !cur.rsp.bvalid;
    nxt.rsp.wready = nxt.rsp.awready;
    if (cur.rsp.bvalid && axil_req.bready)
      nxt.rsp.bvalid = 1'b0;
    if (wr_fire)
    begin
      nxt.rsp.bvalid = 1'b1;
      nxt.rsp.bresp = `RESP_OKAY;
      case (axil_req.awaddr)
        `OFS_CTRL:
        begin
          if (axil_req.wstrb[0])
          begin
            nxt.run = axil_req.wdata[`CTRL_RUN_BIT];
            nxt.psa = axil_req.wdata[`CTRL_PSA_BIT];
          end
        end
        `OFS_PCLH:
        begin
          if (axil_req.wstrb[0])
            nxt.pc_high_latch = axil_req.wdata[7:0];
        end
        `OFS_STATUS, `OFS_ACC, `OFS_PC:
        begin
        end
        default:
          nxt.rsp.bresp = `RESP_SLVERR;
      endcase
    end

    // Bus read channel
    nxt.rsp.arready = axil_req.arvalid && !cur.rsp.arready && !cur.rsp.rvalid;
    if (cur.rsp.rvalid && axil_req.rready)
      nxt.rsp.rvalid = 1'b0;
    if (rd_fire)
    begin
      nxt.rsp.rvalid = 1'b1;
      nxt.rsp.rresp = `RESP_OKAY;
      case (axil_req.araddr)
        `OFS_CTRL:
        begin
          rd_word[`CTRL_RUN_BIT] = cur.run;
          rd_word[`CTRL_PSA_BIT] = cur.psa;
        end
        `OFS_PCLH:
          rd_word[7:0] = cur.pc_high_latch;
        `OFS_STATUS:
        begin
          rd_word[`ST_Z_BIT] = cur.z;
          rd_word[`ST_PD_BIT] = cur.pd_n;
          rd_word[`ST_TO_BIT] = cur.to_n;
        end
        `OFS_ACC:
          rd_word[7:0] = cur.acc;
        `OFS_PC:
          rd_word[12:0] = cur.exec_pc;
        default:
          nxt.rsp.rresp = `RESP_SLVERR;
      endcase
      nxt.rsp.rdata = rd_word;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cur <= RESET_STATE;
    else
      cur <= nxt;
  end

  // Data registers are not reset, as in a RAM
  always_ff @(posedge sys_clk)
  begin
    if (file_wr)
      file_mem[f_addr] <= file_wdata;
  end

  // ==================================================
  // Return stack
  return_stack u_stack (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(push_call),
    .push_data(cur.exec_pc + `PC_STEP),
    .top(stack_top_entry)
  );

  assign prog_addr = cur.pc;
  assign wdt_clear = cur.wdt_clear;
  assign prescaler_clear = cur.prescaler_clear;
  assign axil_rsp = cur.rsp;

  // ==================================================
  // Checks
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence call_seen;
    kind == KIND_CALL;
  endsequence

  sequence bubble_slot;
    cur.flush && (kind == KIND_NONE);
  endsequence

  sequence skip_hit;
    (kind == KIND_DECSKIP) && (dec_res == `CLEAR_BYTE);
  endsequence

  call_push_a: assert property (call_seen |=>
    stack_top_entry == $past(cur.exec_pc) + `PC_STEP)
    else $error("call pushed wrong return address");

  call_target_a: assert property (call_seen |=>
    prog_addr == $past(call_target))
    else $error("call target not loaded");

  call_cycles_a: assert property (call_seen |=> bubble_slot ##0
    ($stable(cur.z) && $stable(cur.acc)))
    else $error("call not two cycles or changed flags");

  wdt_pulse_a: assert property ((kind == KIND_WDCLR) |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong");

  prescaler_clr_a: assert property ((kind == KIND_WDCLR) |=>
    prescaler_clear == $past(cur.psa))
    else $error("prescaler clear does not follow assignment");

  wdt_flags_a: assert property ((kind == KIND_WDCLR) && !watchdog_timeout |=>
    cur.to_n && cur.pd_n && $stable(cur.z))
    else $error("watchdog clear flags wrong");

  reg_clear_a: assert property ((kind == KIND_REGCLR) |=>
    cur.z && (file_mem[$past(f_addr)] == `CLEAR_BYTE))
    else $error("register clear failed");

  acc_clear_a: assert property ((kind == KIND_ACCCLR) |=>
    (cur.acc == `CLEAR_BYTE) && cur.z)
    else $error("accumulator clear failed");

  invert_res_a: assert property ((kind == KIND_INV) && !dest |=>
    cur.acc == ~$past(operand))
    else $error("complement result wrong");

  dec_file_a: assert property ((kind == KIND_DEC) && dest |=>
    (file_mem[$past(f_addr)] == $past(dec_res)) && $stable(cur.acc))
    else $error("decrement to register wrong");

  skip_flags_a: assert property ((kind == KIND_DECSKIP) && !watchdog_timeout |=>
    $stable(cur.z) && $stable(cur.to_n) && $stable(cur.pd_n))
    else $error("decrement-skip altered a flag");

  skip_zero_a: assert property (skip_hit |=> bubble_slot)
    else $error("zero result did not skip");

  skip_miss_a: assert property ((kind == KIND_DECSKIP) && (dec_res != `CLEAR_BYTE)
    |=> !cur.flush)
    else $error("nonzero result skipped");

  zero_flag_a: assert property (((kind == KIND_INV) || (kind == KIND_DEC)) |=>
    cur.z == ($past(alu_res) == `CLEAR_BYTE))
    else $error("zero flag wrong");

endmodule

// >>> dv/prog_rom_model.sv
// Program memory model feeding instruction words to the core
`timescale 1ns/1ps

module prog_rom_model
(
  // Clock
  input wire logic sys_clk,
  // Fetch port
  input wire logic [12:0] prog_addr,
  output logic [13:0] instr_word
);
  // ==================================================
  // Storage, loaded by the bench only while the core is halted
  logic [13:0] mem [0:8191];

  // Synchronous read: word shows the cycle after its address, like the real array
  always_ff @(posedge sys_clk)
  begin
    instr_word <= mem[prog_addr];
  end
endmodule

// >>> dv/test_core_exec_ops.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`include "core_ops_cfg.svh"

module test_core_exec_ops
  import core_ops_pkg::*;
;
  // ==================================================
  // Signals and counters
  logic sys_clk, rst, watchdog_timeout, wdt_clear, prescaler_clear;
  logic [12:0] prog_addr, stack_top_entry, t;
  logic [13:0] instr_word;
  axil_req_t axil_req;
  axil_rsp_t axil_rsp;
  logic [31:0] seed, rd, r;
  logic [1:0] resp;
  logic [6:0] f;
  logic [7:0] ev;
  int err_count = 0, n_compared = 0, n_cyc = 0, n_wd = 0, n_ps = 0, k;

  core_exec_ops u_core_exec_ops (.sys_clk(sys_clk), .rst(rst), .prog_addr(prog_addr),
    .instr_word(instr_word), .watchdog_timeout(watchdog_timeout), .wdt_clear(wdt_clear),
    .prescaler_clear(prescaler_clear), .stack_top_entry(stack_top_entry),
    .axil_req(axil_req), .axil_rsp(axil_rsp));
  prog_rom_model u_prog_rom_model (.sys_clk(sys_clk), .prog_addr(prog_addr),
    .instr_word(instr_word));

  // ==================================================
  // Clock, pulse counting and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    n_cyc++;
    if (wdt_clear === 1'b1) n_wd++;
    if (prescaler_clear === 1'b1) n_ps++;
    if (n_cyc == 20000)
    begin
      err_count++;
      $display("Error at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  // ==================================================
  // Helpers
  task tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Galois shift register; stays repeatable from the fixed seed
  function logic [31:0] get_rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
    return seed;
  endfunction

  function automatic logic [13:0] op(input logic [13:0] base, input logic d, input logic [6:0] a);
    return base | {6'h00, d, a};
  endfunction

  // Expected STATUS word: both active-low flags high, zero flag as given
  function automatic logic [31:0] st(input logic z);
    return {27'h0000000, 2'b11, 2'b00, z};
  endfunction

  // Master holds each channel until its own ready, response ready until answered
  task bus_write(input logic [7:0] a, input logic [31:0] d);
    axil_req.awvalid <= 1'b1;
    axil_req.awaddr <= a;
    axil_req.wvalid <= 1'b1;
    axil_req.wdata <= d;
    axil_req.wstrb <= 4'hF;
    axil_req.bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
      if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
      if (axil_rsp.bvalid) break;
    end
    resp = axil_rsp.bresp;
    axil_req.bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task bus_read(input logic [7:0] a);
    axil_req.arvalid <= 1'b1;
    axil_req.araddr <= a;
    axil_req.rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
      if (axil_rsp.rvalid) break;
    end
    resp = axil_rsp.rresp;
    rd = axil_rsp.rdata;
    axil_req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Reset also wipes the program so every test starts from address zero
  task do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 8192; i++) u_prog_rom_model.mem[i] = 14'h0000;
  endtask

  task load(input logic [13:0] w [8]);
    for (int i = 0; i < 8; i++) u_prog_rom_model.mem[i] = w[i];
  endtask

  // Run until the fetch address reaches stop, bounded, then halt the core
  task run_to(input logic [12:0] stop, input logic psa);
    int n;
    n = 0;
    bus_write(`OFS_CTRL, {30'h0, psa, 1'b1});
    while (prog_addr !== stop && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    check({19'h0, prog_addr}, {19'h0, stop}, "fetch address");
    bus_write(`OFS_CTRL, 32'h00000000);
  endtask

  task expect_core(input logic [7:0] acc, input logic z, input string what);
    bus_read(`OFS_ACC);
    check(rd, {24'h0, acc}, what);
    bus_read(`OFS_STATUS);
    check(rd, st(z), what);
  endtask

  // ==================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    watchdog_timeout = 1'b0;
    axil_req = '0;
    seed = 32'hC7A93C75;
    do_reset();
    bus_read(`OFS_STATUS);
    check(rd, 32'h00000018, "status after reset");
    bus_read(8'h40);
    check({30'h0, resp}, 32'h00000002, "unmapped response");
    $display("test reset and bus done");
    repeat (3)
    begin
      r = get_rnd();
      f = r[6:0];
      k = int'(r[10:8]) + 1;
      // Clear then k decrements back into the register, then one more to the accumulator
      do_reset();
      u_prog_rom_model.mem[0] = op(`OP_REGCLR_VAL, 1'b0, f);
      for (int i = 1; i <= k; i++) u_prog_rom_model.mem[i] = op(`OP_DEC_VAL, 1'b1, f);
      u_prog_rom_model.mem[k + 1] = op(`OP_DEC_VAL, 1'b0, f);
      run_to(13'(k + 3), r[12]);
      ev = 8'h00 - 8'(k) - 8'h01;
      expect_core(ev, ev == 8'h00, "decrement chain");
      // Invert to the accumulator, back to the register, then read back as zero
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_INV_VAL, 1'b0, f), op(`OP_INV_VAL, 1'b1, f),
        op(`OP_INV_VAL, 1'b0, f), 14'h0000, 14'h0000, 14'h0000, 14'h0000});
      run_to(13'h0005, 1'b0);
      expect_core(8'h00, 1'b1, "invert");
      // Accumulator clear after a nonzero result
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_DEC_VAL, 1'b0, f), `OP_ACCCLR_VAL,
        14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000});
      run_to(13'h0004, 1'b0);
      expect_core(8'h00, 1'b1, "accumulator clear");
      // Register becomes 01, skip on zero result discards the following decrement
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_DEC_VAL, 1'b1, f), op(`OP_DEC_VAL, 1'b1, f),
        op(`OP_INV_VAL, 1'b1, f), `OP_ACCCLR_VAL, op(`OP_DECSKIP_VAL, 1'b1, f),
        op(`OP_DEC_VAL, 1'b0, f), 14'h0000});
      run_to(13'h0008, 1'b0);
      expect_core(8'h00, 1'b1, "skip on zero");
      // Nonzero result: next word runs, zero flag untouched by the skip itself
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_DEC_VAL, 1'b0, f), op(`OP_DECSKIP_VAL, 1'b1, f),
        op(`OP_INV_VAL, 1'b0, f), 14'h0000, 14'h0000, 14'h0000, 14'h0000});
      run_to(13'h0005, 1'b0);
      expect_core(8'h00, 1'b1, "no skip");
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_DECSKIP_VAL, 1'b0, f), 14'h0000, 14'h0000,
        14'h0000, 14'h0000, 14'h0000, 14'h0000});
      run_to(13'h0003, 1'b0);
      expect_core(8'hFF, 1'b1, "skip keeps flags");
      // Call: slot after it must not run, target gets latch bits on top
      do_reset();
      r = get_rnd();
      t = {r[20:19], 1'b1, r[9:0]};
      load('{op(`OP_REGCLR_VAL, 1'b0, f), 14'h0000, `OP_CALL_VAL | {3'h0, t[10:0]},
        op(`OP_DEC_VAL, 1'b1, f), 14'h0000, 14'h0000, 14'h0000, 14'h0000});
      u_prog_rom_model.mem[t] = op(`OP_INV_VAL, 1'b1, f);
      u_prog_rom_model.mem[t + 1] = op(`OP_INV_VAL, 1'b0, f);
      bus_write(`OFS_PCLH, {24'h0, r[23:21], r[20:19], r[18:16]});
      bus_read(`OFS_PCLH);
      check(rd, {24'h0, r[23:16]}, "latch readback");
      run_to(t + 13'h0003, 1'b0);
      check({19'h0, stack_top_entry}, 32'h00000003, "return address");
      expect_core(8'h00, 1'b1, "call target");
      // Watchdog clear after a timeout, prescaler pulse only when assigned
      do_reset();
      load('{op(`OP_REGCLR_VAL, 1'b0, f), op(`OP_DEC_VAL, 1'b0, f), `OP_WDCLR_VAL,
        14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000});
      watchdog_timeout <= 1'b1;
      @(posedge sys_clk);
      watchdog_timeout <= 1'b0;
      bus_read(`OFS_STATUS);
      check(rd, 32'h00000008, "timeout flag low");
      n_wd = 0;
      n_ps = 0;
      run_to(13'h0004, r[25]);
      check(n_wd, 32'h00000001, "watchdog clear pulses");
      check(n_ps, {31'h0, r[25]}, "prescaler clear pulses");
      expect_core(8'hFF, 1'b0, "watchdog clear flags");
      $display("test round done");
    end
    tally_and_finish();
  end
endmodule
